// ---- glp_pkg.sv ----
// Package for the pin function configuration block: register map,
// field positions, reset values, pin-select codes and timing figures.
// Assumes a 32-bit APB register bus with byte addresses.
package glp_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] GLP_CFG_OFF = 12'h088;
  localparam logic [11:0] GLP_IRQ_STAT_OFF = 12'h0A0;
  localparam logic [11:0] GLP_IRQ_EN_OFF = 12'h0A4;

  // ---------------------------------------------------------------
  // Configuration register fields
  // ---------------------------------------------------------------
  localparam int GLP_LED_LSB = 28;
  localparam int GLP_POL_LSB = 24;
  localparam int GLP_SEL_LSB = 20;
  localparam int GLP_BUF_LSB = 16;
  localparam int GLP_DIR_LSB = 8;
  localparam int GLP_GPO_LSB = 3;
  localparam int GLP_PIN_LSB = 0;
  localparam int GLP_NPINS = 3;
  localparam int GLP_SEL_W = 3;

  localparam logic [31:0] GLP_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] GLP_CFG_WMASK = 32'h7777_071F;
  localparam logic [2:0] GLP_IRQ_RST = 3'h0;

  // ---------------------------------------------------------------
  // Memory pin function codes
  // ---------------------------------------------------------------
  localparam logic [2:0] GLP_SEL_MEM = 3'h0;
  localparam logic [2:0] GLP_SEL_GPO_GPO = 3'h1;
  localparam logic [2:0] GLP_SEL_RSV_A = 3'h2;
  localparam logic [2:0] GLP_SEL_GPO_RXDV = 3'h3;
  localparam logic [2:0] GLP_SEL_RSV_B = 3'h4;
  localparam logic [2:0] GLP_SEL_TXEN_GPO = 3'h5;
  localparam logic [2:0] GLP_SEL_TXEN_RXDV = 3'h6;
  localparam logic [2:0] GLP_SEL_CLKS = 3'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int GLP_CLK_PERIOD_NS = 4;
  localparam int GLP_IRQ_MIN_PULSE_NS = 40;
  localparam int GLP_IRQ_MIN_PULSE_CYC =
    (GLP_IRQ_MIN_PULSE_NS + GLP_CLK_PERIOD_NS - 1) / GLP_CLK_PERIOD_NS;

endpackage

// ---- glp_sync2.sv ----
// Two-flop level synchroniser, one lane per bit.
// Assumes inputs are levels from outside the ref_clk domain.
`timescale 1ns/1ps
module glp_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- glp_pin_config.sv ----
// Pin function configuration: three shared LED/GPIO pins, two general
// outputs and the function select of the serial memory pins, with a
// level-sensitive pin interrupt and an APB register slave.
// Assumes a single 250 MHz clock; pin and monitor inputs are async.
//
// Functional notes
// R1 - Each shared pin drives its LED signal when its LED select bit is set, else acts as GPIO.
// R2 - Polarity one makes a high level on a pin set its interrupt status bit.
// R3 - Polarity zero makes a low level on a pin set its interrupt status bit.
// R4 - A pin interrupt reaches the host only when its enable bit is set too.
// R5 - Outside logic holds an interrupt level over 40 ns to be sure it is seen.
// R6 - The select field routes the data pin to memory data, general out 3, TX enable or TX clock.
// R7 - The same field routes the clock pin to memory clock, general out 4, RX valid or RX clock.
// R8 - Software never writes the reserved select codes 010 and 100.
// R9 - Software never changes the select field during a memory cycle.
// R10 - Driver type bit one gives push-pull, zero gives open-drain.
// R11 - Direction bit one makes the pin an output, zero an input.
// R12 - Bits 3 and 4 drive general outputs 3 and 4.
// R13 - An output pin drives the value written to its data bit.
// R14 - Reading the pin data bits returns the live pin levels.
// R15 - Reserved bits read zero and ignore writes; all fields reset to zero.
// R16 - General output data reaches a pin only when the select field gives it that function.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module glp_pin_config (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [glp_pkg::GLP_NPINS-1:0] led_status,
  input wire logic [glp_pkg::GLP_NPINS-1:0] gpio_in,
  output logic [glp_pkg::GLP_NPINS-1:0] gpio_out,
  output logic [glp_pkg::GLP_NPINS-1:0] gpio_oe,
  input wire logic mem_ctrl_data_out,
  input wire logic mem_ctrl_data_oe,
  output logic mem_ctrl_data_in,
  input wire logic mem_ctrl_clk,
  input wire logic tx_en_mon,
  input wire logic tx_clk_mon,
  input wire logic rx_dv_mon,
  input wire logic rx_clk_mon,
  input wire logic serial_mem_data_pin_in,
  output logic serial_mem_data_pin_out,
  output logic serial_mem_data_pin_oe,
  output logic serial_mem_clock_pin_out,
  output logic serial_mem_clock_pin_oe
);
  import glp_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] async_bus;
  logic [7:0] sync_bus;
  logic [GLP_NPINS-1:0] pin_level;
  logic mem_data_s;
  logic tx_en_s;
  logic tx_clk_s;
  logic rx_dv_s;
  logic rx_clk_s;

  // Pulled-up pin lanes travel inverted, so reset zeros read as idle highs
  assign async_bus = {rx_clk_mon, rx_dv_mon, tx_clk_mon, tx_en_mon,
                      ~serial_mem_data_pin_in, ~gpio_in};

  glp_sync2 #(.W(8)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  assign pin_level = ~sync_bus[2:0];
  assign mem_data_s = ~sync_bus[3];
  assign tx_en_s = sync_bus[4];
  assign tx_clk_s = sync_bus[5];
  assign rx_dv_s = sync_bus[6];
  assign rx_clk_s = sync_bus[7];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [GLP_NPINS-1:0] irq_stat_q;
  logic [GLP_NPINS-1:0] irq_en_q;
  logic [31:0] prdata_q;

  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire hit_cfg = (paddr == GLP_CFG_OFF);
  wire hit_stat = (paddr == GLP_IRQ_STAT_OFF);
  wire hit_en = (paddr == GLP_IRQ_EN_OFF);
  wire hit_any = hit_cfg | hit_stat | hit_en;
  wire wr_ok = access_ph & pwrite & hit_any;
  wire wr_cfg = wr_ok & hit_cfg;
  wire wr_stat = wr_ok & hit_stat;
  wire wr_en = wr_ok & hit_en;
  wire [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                           {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] cfg_wmask = lane_mask & GLP_CFG_WMASK;

  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata = prdata_q;

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  wire [2:0] led_sel = cfg_q[GLP_LED_LSB +: GLP_NPINS];
  wire [2:0] irq_pol = cfg_q[GLP_POL_LSB +: GLP_NPINS];
  wire [2:0] mem_sel = cfg_q[GLP_SEL_LSB +: GLP_SEL_W];
  wire [2:0] drv_pp = cfg_q[GLP_BUF_LSB +: GLP_NPINS];
  wire [2:0] pin_dir = cfg_q[GLP_DIR_LSB +: GLP_NPINS];
  wire general_out_3_val = cfg_q[GLP_GPO_LSB];
  wire general_out_4_val = cfg_q[GLP_GPO_LSB + 1];
  wire [2:0] pin_data = cfg_q[GLP_PIN_LSB +: GLP_NPINS];

  // Reserved bits never store; pin data bits store for output drive
  wire [31:0] cfg_d = (cfg_q & ~cfg_wmask) | (pwdata & cfg_wmask); // R15

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_q <= GLP_CFG_RST; // R15
    end else if (wr_cfg) begin
      cfg_q <= cfg_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [31:0] cfg_rd = {cfg_q[31:GLP_GPO_LSB], pin_level}; // R14
  wire [31:0] rd_mux = hit_cfg ? (cfg_rd & GLP_CFG_WMASK) : // R15
                       hit_stat ? {29'h0, irq_stat_q} :
                       hit_en ? {29'h0, irq_en_q} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Pin interrupts
  // ---------------------------------------------------------------
  wire [2:0] hit_hi = pin_level & irq_pol; // R2
  wire [2:0] hit_lo = ~pin_level & ~irq_pol; // R3
  wire [2:0] irq_set = hit_hi | hit_lo;
  wire [2:0] stat_clr = wr_stat & pstrb[0] ? pwdata[2:0] : 3'h0;
  wire [2:0] irq_stat_d = irq_set | (irq_stat_q & ~stat_clr);
  wire [2:0] irq_en_d = (wr_en & pstrb[0]) ? pwdata[2:0] : irq_en_q;
  wire irq_d = |(irq_stat_d & irq_en_d); // R4
  logic irq_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat_q <= GLP_IRQ_RST;
      irq_en_q <= GLP_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  // ---------------------------------------------------------------
  // Shared LED / GPIO pin drivers
  // ---------------------------------------------------------------
  logic [2:0] gpio_out_q;
  logic [2:0] gpio_oe_q;

  genvar gi;
  generate
    for (gi = 0; gi < GLP_NPINS; gi++) begin : g_pin
      wire src = led_sel[gi] ? led_status[gi] : pin_data[gi]; // R1 R13
      wire drv = led_sel[gi] | pin_dir[gi]; // R11
      wire out_d = drv_pp[gi] & src; // R10
      wire oe_d = drv & (drv_pp[gi] | ~src); // R10
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          gpio_out_q[gi] <= 1'b0;
          gpio_oe_q[gi] <= 1'b0;
        end else begin
          gpio_out_q[gi] <= out_d;
          gpio_oe_q[gi] <= oe_d;
        end
      end
    end
  endgenerate

  assign gpio_out = gpio_out_q;
  assign gpio_oe = gpio_oe_q;

  // ---------------------------------------------------------------
  // Memory pin function select
  // ---------------------------------------------------------------
  logic dpin_out_d;
  logic dpin_oe_d;
  logic cpin_out_d;
  logic cpin_oe_d;

  always_comb begin
    dpin_out_d = 1'b0;
    dpin_oe_d = 1'b0;
    case (mem_sel) // R6 R12 R16
      GLP_SEL_MEM: begin
        dpin_out_d = mem_ctrl_data_out;
        dpin_oe_d = mem_ctrl_data_oe;
      end
      GLP_SEL_GPO_GPO, GLP_SEL_GPO_RXDV: begin
        dpin_out_d = general_out_3_val;
        dpin_oe_d = 1'b1;
      end
      GLP_SEL_TXEN_GPO, GLP_SEL_TXEN_RXDV: begin
        dpin_out_d = tx_en_s;
        dpin_oe_d = 1'b1;
      end
      GLP_SEL_CLKS: begin
        dpin_out_d = tx_clk_s;
        dpin_oe_d = 1'b1;
      end
      default: begin
        dpin_out_d = 1'b0;
        dpin_oe_d = 1'b0;
      end
    endcase
  end

  always_comb begin
    cpin_out_d = 1'b0;
    cpin_oe_d = 1'b0;
    case (mem_sel) // R7 R12 R16
      GLP_SEL_MEM: begin
        cpin_out_d = mem_ctrl_clk;
        cpin_oe_d = 1'b1;
      end
      GLP_SEL_GPO_GPO, GLP_SEL_TXEN_GPO: begin
        cpin_out_d = general_out_4_val;
        cpin_oe_d = 1'b1;
      end
      GLP_SEL_GPO_RXDV, GLP_SEL_TXEN_RXDV: begin
        cpin_out_d = rx_dv_s;
        cpin_oe_d = 1'b1;
      end
      GLP_SEL_CLKS: begin
        cpin_out_d = rx_clk_s;
        cpin_oe_d = 1'b1;
      end
      default: begin
        cpin_out_d = 1'b0;
        cpin_oe_d = 1'b0;
      end
    endcase
  end

  logic dpin_out_q;
  logic dpin_oe_q;
  logic cpin_out_q;
  logic cpin_oe_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dpin_out_q <= 1'b0;
      dpin_oe_q <= 1'b0;
      cpin_out_q <= 1'b0;
      cpin_oe_q <= 1'b0;
    end else begin
      dpin_out_q <= dpin_out_d;
      dpin_oe_q <= dpin_oe_d;
      cpin_out_q <= cpin_out_d;
      cpin_oe_q <= cpin_oe_d;
    end
  end

  assign serial_mem_data_pin_out = dpin_out_q;
  assign serial_mem_data_pin_oe = dpin_oe_q;
  assign serial_mem_clock_pin_out = cpin_out_q;
  assign serial_mem_clock_pin_oe = cpin_oe_q;
  // Memory controller always sees the synchronised data pin
  assign mem_ctrl_data_in = mem_data_s;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_led_pin_drive: assert property ( // R1
    (led_sel[0] & drv_pp[0]) |=> (gpio_oe[0] && gpio_out[0] ==
      $past(led_status[0])))
    else $error("led pin 0 not driven from led status");

  a_irq_high_set: assert property ( // R2
    1'b1 |=> (($past(hit_hi) & ~irq_stat_q) == 3'h0))
    else $error("high level did not set status");

  a_irq_low_set: assert property ( // R3
    (pin_level == 3'h0 && irq_pol == 3'h0) |=> irq_stat_q == 3'h7)
    else $error("low level did not set status");

  a_irq_gate_en: assert property ( // R4
    (irq_en_q == 3'h0 && !wr_en) [*2] |-> !irq)
    else $error("interrupt raised with all enables clear");

  a_general_out_3_route: assert property ( // R6
    (mem_sel == GLP_SEL_GPO_GPO || mem_sel == GLP_SEL_GPO_RXDV) |=>
      (serial_mem_data_pin_oe && serial_mem_data_pin_out ==
       $past(general_out_3_val)))
    else $error("data pin not carrying general out 3");

  a_clk_rxclk: assert property ( // R7
    (mem_sel == GLP_SEL_CLKS) |=>
      serial_mem_clock_pin_out == $past(rx_clk_s))
    else $error("clock pin not carrying rx clock");

  a_open_drain: assert property ( // R10
    (!drv_pp[1] && pin_dir[1] && !led_sel[1]) |=>
      (!gpio_out[1] && gpio_oe[1] == !$past(pin_data[1])))
    else $error("open-drain pin 1 driven high");

  a_dir_input: assert property ( // R11
    1'b1 |=> ((gpio_oe & ~$past(pin_dir | led_sel)) == 3'h0))
    else $error("input pin has output enable");

  a_gpio_drive: assert property ( // R13
    (drv_pp[2] && pin_dir[2] && !led_sel[2]) |=>
      (gpio_oe[2] && gpio_out[2] == $past(pin_data[2])))
    else $error("output pin 2 not driving its data bit");

  a_pin_readback: assert property ( // R14
    (setup_ph && !pwrite && hit_cfg) |=>
      prdata[2:0] == $past(pin_level))
    else $error("pin data read not live level");

  a_rsvd_zero: assert property ( // R15
    (setup_ph && hit_cfg) |=> ((prdata & ~GLP_CFG_WMASK) == 32'h0))
    else $error("reserved bits read nonzero");

  a_mem_passthru: assert property ( // R16
    (mem_sel == GLP_SEL_MEM) |=>
      (serial_mem_data_pin_out == $past(mem_ctrl_data_out) &&
       serial_mem_clock_pin_out == $past(mem_ctrl_clk)))
    else $error("memory pins not passing controller signals");

endmodule

// ---- glp_board.sv ----
// Board model: pull-ups on the three shared pins and the memory data pin.
// Assumes the bench drives a shared pin only while the block releases it.
`timescale 1ns/1ps
module glp_board (
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe,
  input wire logic [2:0] ext_oe,
  input wire logic [2:0] ext_val,
  output logic [2:0] gpio_lvl,
  input wire logic mem_out,
  input wire logic mem_oe,
  output logic mem_lvl
);
  // ---------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------
  // Released pins float up unless the bench drives them, so open-drain highs read as one
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      gpio_lvl[i] = gpio_oe[i] ? gpio_out[i]
        : (ext_oe[i] ? ext_val[i] : 1'b1);
    end
  end
  assign mem_lvl = mem_oe ? mem_out : 1'b1;
endmodule

// ---- glp_pin_config_tb.sv ----
// Self-checking bench for the pin function configuration block.
// Assumes the board model and an APB master built from tasks here.
`timescale 1ns/1ps
module glp_pin_config_tb;
  import glp_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [2:0] led_status = 3'h5;
  logic [2:0] gpio_in;
  logic [2:0] gpio_out;
  logic [2:0] gpio_oe;
  logic [2:0] ext_oe = 3'h0;
  logic [2:0] ext_val = 3'h0;
  logic mdout = 1'b0;
  logic mdoe = 1'b0;
  logic mdin;
  logic mclk = 1'b0;
  logic txen = 1'b0;
  logic txclk = 1'b0;
  logic rxdv = 1'b0;
  logic rxclk = 1'b0;
  logic dpin_in;
  logic dpin_out;
  logic dpin_oe;
  logic cpin_out;
  logic cpin_oe;
  logic [31:0] rd;
  logic e;
  logic [31:0] x;
  int miscompares = 0;
  int checks = 0;

  always #2 ref_clk = ~ref_clk;

  glp_pin_config dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .led_status(led_status),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .mem_ctrl_data_out(mdout), .mem_ctrl_data_oe(mdoe),
    .mem_ctrl_data_in(mdin), .mem_ctrl_clk(mclk), .tx_en_mon(txen),
    .tx_clk_mon(txclk), .rx_dv_mon(rxdv), .rx_clk_mon(rxclk),
    .serial_mem_data_pin_in(dpin_in),
    .serial_mem_data_pin_out(dpin_out),
    .serial_mem_data_pin_oe(dpin_oe),
    .serial_mem_clock_pin_out(cpin_out),
    .serial_mem_clock_pin_oe(cpin_oe)
  );

  glp_board board_u (
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_oe(ext_oe),
    .ext_val(ext_val), .gpio_lvl(gpio_in), .mem_out(dpin_out),
    .mem_oe(dpin_oe), .mem_lvl(dpin_in)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task conclude;
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        conclude();
      end
      @(posedge ref_clk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Pin outputs as {data oe, data out, clock oe, clock out}
  function logic [31:0] sel_exp(input int c, input int p);
    logic b;
    b = p[0];
    case (c)
      0: return {28'h0, ~b, 1'b0, 1'b1, 1'b0};
      1: return {28'h0, 1'b1, b, 1'b1, b};
      3: return {28'h0, 1'b1, b, 1'b1, ~b};
      5: return {28'h0, 1'b1, ~b, 1'b1, b};
      6: return {28'h0, 1'b1, ~b, 1'b1, ~b};
      7: return 32'hF;
      default: return 32'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wt(4);
    rdchk(GLP_CFG_OFF, 32'h0000_0007);
    rdchk(GLP_IRQ_STAT_OFF, 32'h0);
    chk({29'h0, gpio_oe}, 32'h0);
    apb(1'b1, GLP_CFG_OFF, 32'hFFFF_FFFF);
    wt(6);
    rdchk(GLP_CFG_OFF, 32'h7777_071D);
    chk({26'h0, gpio_oe, gpio_out}, 32'h3D);
    apb(1'b1, GLP_CFG_OFF, 32'h0007_0702);
    wt(6);
    chk({26'h0, gpio_oe, gpio_out}, 32'h3A);
    rdchk(GLP_CFG_OFF, 32'h0007_0702);
    apb(1'b1, GLP_CFG_OFF, 32'h0000_0702);
    wt(6);
    chk({26'h0, gpio_oe, gpio_out}, 32'h28);
    rdchk(GLP_CFG_OFF, 32'h0000_0702);
    ext_oe <= 3'h7;
    ext_val <= 3'h6;
    apb(1'b1, GLP_CFG_OFF, 32'h0000_0001);
    wt(6);
    chk({29'h0, gpio_oe}, 32'h0);
    rdchk(GLP_CFG_OFF, 32'h0000_0006);
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 2; p++) begin
        if (c == 2 || c == 4) continue;
        txen <= !p;
        rxdv <= !p;
        mdoe <= !p;
        txclk <= 1'b1;
        rxclk <= 1'b1;
        apb(1'b1, GLP_CFG_OFF, (c << 20) | (p << 4) | (p << 3));
        wt(6);
        x = sel_exp(c, p);
        chk({dpin_oe, dpin_out, cpin_oe, cpin_out}, x);
        chk({31'h0, mdin}, {31'h0, x[3] ? x[2] : 1'b1});
      end
    end
    ext_val <= 3'h0;
    apb(1'b1, GLP_CFG_OFF, 32'h0700_0000);
    wt(6);
    apb(1'b1, GLP_IRQ_STAT_OFF, 32'h7);
    rdchk(GLP_IRQ_STAT_OFF, 32'h0);
    ext_val <= 3'h2;
    wt(15);
    rdchk(GLP_IRQ_STAT_OFF, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, GLP_IRQ_EN_OFF, 32'h2);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    ext_val <= 3'h0;
    wt(6);
    apb(1'b1, GLP_IRQ_STAT_OFF, 32'h7);
    rdchk(GLP_IRQ_STAT_OFF, 32'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, GLP_CFG_OFF, 32'h0300_0000);
    wt(6);
    rdchk(GLP_IRQ_STAT_OFF, 32'h4);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, GLP_IRQ_EN_OFF, 32'h4);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h08C, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1);
    rdchk(12'h08C, 32'h0);
    rdchk(GLP_CFG_OFF, 32'h0300_0000);
    conclude();
  end
endmodule
